// ==== rtl/swf_sink.sv ====
/*
 Streaming word framer, sink end: takes one 16-bit word plus the
 control/data flag each clock from the link pins, decodes control words,
 checks the diagonal parity and delivers payload words through a 16-word
 buffer with packet first/last marks. Also holds the buffer module.
 Assumes the far source sends one word per clk_in cycle, synchronous to
 clk_in but from outside logic, so the pins are double registered.
*/
// Overview of operation
// RL1: control word type sits on bits 15 and 12; 00 idle, 01 address, 1x payload.
// RL2: end status on bits 14:13 reports the payload transfer just before it.
// RL3: end status counts only in the first control word after payload data.
// RL4: status 00 no end, 01 abort, 10 two bytes valid, 11 one byte.
// RL5: in fabric side mode payload control bits 14:13 are an address type.
// RL6: address field bits 11:4 in idle/payload words, 11:0 in address words.
// RL7: source sends idle control word address field as zeros.
// RL8: idle and payload control words carry four-bit diagonal odd parity in 3:0.
// RL9: address data words appear only between address and payload control words.
// RL10: payload data words carry 16 bits, told apart only by the flag.
// RL11: source advances one state per word cycle.
// RL12: source sends idle control words when nothing is to be sent.
// RL13: every extended burst starts with one address control word.
// RL14: at most eight address data words follow an address control word.
// RL15: a payload control word begins each basic burst and ends extended sequences.
// RL16: data burst lasts until segment byte limit or packet end.
// RL17: training states send training control or data words each cycle.
// RL18: idle, training, payload control words carry parity; address control words do not.
// RL19: unused address bits are zero, counted in parity, otherwise ignored.
// RL20: parity covers words since last parity word; training control covers only itself.
// RL21: diagonal sum with slot ones, bytes folded, then nibbles folded.
// RL22: the control/data flag is left out of the parity.
// RL23: control sequence is optional address word, address data, one payload word.
// RL24: control word msb is driven on data bit 15.
// RL25: training control is 0x0fff with parity 1111, training data 0xf000.
// RL26: computed parity is compared at each parity word; mismatch raises an error.

`include "swf_consts.svh"

module swf_fifo #(
	parameter int WIDTH = 30,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// fill side
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// drain side
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;
	logic push;
	logic pop;

	// output stage refills when empty or when consumed
	assign push = in_valid_in && (count_reg != (AW+1)'(DEPTH));
	assign pop = (count_reg != '0) && (!out_valid_reg || out_ready_in);
	assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_out = out_valid_reg;
	assign out_data_out = out_data_reg;

	// storage array, no reset needed
	always_ff @(posedge clk_in)
	begin
		if (push)
		begin
			mem[wr_ptr_reg] <= in_data_in;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// registered head so the drain side sees flop outputs
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end
		else if (pop)
		begin
			out_valid_reg <= 1'b1;
			out_data_reg <= mem[rd_ptr_reg];
		end
		else if (out_ready_in)
		begin
			out_valid_reg <= 1'b0;
		end
	end

endmodule // swf_fifo

module swf_sink (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// link pins from the source
	input wire logic [15:0] link_word_in,
	input wire logic link_ctl_in,
	// configuration
	input wire logic fabric_side_mode_in,
	// delivered payload words
	output logic pkt_valid_out,
	output swf_pkg::swf_pkt_t pkt_word_out,
	input wire logic pkt_ready_in,
	// status
	output logic parity_err_out,
	output logic overflow_out,
	output logic training_out,
	output logic [11:0] ext_addr_out
);
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [15:0] word_meta_reg;
	logic [15:0] word_reg;
	logic ctl_meta_reg;
	logic ctl_reg;
	logic [15:0] acc_reg;
	logic [15:0] acc_next;
	logic [15:0] word_slot;
	logic [7:0] fold8;
	logic [3:0] dip_calc;
	logic [1:0] control_word_type;
	logic [1:0] es;
	logic is_train;
	logic is_acw;
	logic is_pcw;
	logic parity_word;
	logic es_valid;
	swf_pkg::swf_phase_t phase_reg;
	logic in_train_reg;
	logic first_reg;
	logic [7:0] seg_addr_reg;
	logic [1:0] seg_at_reg;
	logic pend_valid_reg;
	swf_pkg::swf_pkt_t pend_reg;
	swf_pkg::swf_pkt_t push_word;
	logic push_valid;
	logic fifo_ready;
	logic parity_err_reg;
	logic overflow_reg;
	logic [11:0] ext_addr_reg;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rst_sync_reg <= 2'h0;
		end
		else
		begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// pins come from outside logic, two flops before use
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			word_meta_reg <= 16'h0000;
			word_reg <= 16'h0000;
			ctl_meta_reg <= 1'b0;
			ctl_reg <= 1'b0;
		end
		else
		begin
			word_meta_reg <= link_word_in;
			word_reg <= word_meta_reg;
			ctl_meta_reg <= link_ctl_in;
			ctl_reg <= ctl_meta_reg;
		end
	end

	// word decode; bit 15 is the control word msb
	assign control_word_type = {word_reg[`SWF_CWT_HI_BIT], word_reg[`SWF_CWT_LO_BIT]}; // RL1 RL24
	assign es = word_reg[`SWF_ES_HI:`SWF_ES_LO]; // RL2
	assign is_train = ctl_reg && (word_reg == `SWF_TRAIN_CTL); // RL25 RL17
	assign is_acw = ctl_reg && !is_train && (control_word_type == `SWF_CWT_ADDR); // RL13
	assign is_pcw = ctl_reg && !is_train && control_word_type[1]; // RL15
	assign parity_word = ctl_reg && !is_acw; // RL18 RL8
	// status counts only right after payload data; fabric mode reuses the bits
	assign es_valid = ctl_reg && !is_train && !(is_pcw && fabric_side_mode_in); // RL3 RL5

	// diagonal sum: rotate the running sum and fold in each word except a training control word, which is summed alone; flag excluded
	always_comb
	begin
		word_slot = word_reg;
		if (parity_word)
		begin
			word_slot = {word_reg[15:4], `SWF_DIP_FILL}; // RL21
		end
		if (is_train)
		begin
			acc_next = word_slot; // RL20
		end
		else
		begin
			acc_next = {acc_reg[14:0], acc_reg[15]} ^ word_slot; // RL21 RL22 RL19
		end
	end
	assign fold8 = acc_next[15:8] ^ acc_next[7:0]; // RL21
	assign dip_calc = fold8[7:4] ^ fold8[3:0]; // RL21

	// running sum restarts after every parity-bearing word
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_reg <= `SWF_ACC_RESET;
		end
		else if (parity_word)
		begin
			acc_reg <= `SWF_ACC_RESET; // RL20
		end
		else
		begin
			acc_reg <= acc_next;
		end
	end

	// error pulse for one cycle on any parity miss
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			parity_err_reg <= 1'b0;
		end
		else
		begin
			parity_err_reg <= parity_word && (dip_calc != word_reg[`SWF_DIP_HI:0]); // RL26 RL8
		end
	end

	// stream phase from each control word; data words never change it
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_reg <= swf_pkg::SWF_PH_IDLE;
		end
		else if (ctl_reg)
		begin
			if (is_train)
			begin
				phase_reg <= swf_pkg::SWF_PH_TRAIN; // RL17
			end
			else if (is_acw)
			begin
				phase_reg <= swf_pkg::SWF_PH_ADDR; // RL9
			end
			else if (is_pcw)
			begin
				phase_reg <= swf_pkg::SWF_PH_PAYLOAD; // RL15
			end
			else
			begin
				phase_reg <= swf_pkg::SWF_PH_IDLE; // RL12
			end
		end
	end

	// training indication and extended address capture
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_train_reg <= 1'b0;
			ext_addr_reg <= 12'h000;
		end
		else
		begin
			if (ctl_reg)
			begin
				in_train_reg <= is_train;
			end
			if (is_acw)
			begin
				ext_addr_reg <= word_reg[`SWF_ACW_ADF_HI:0]; // RL6
			end
		end
	end

	// segment header from the payload control word
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			first_reg <= 1'b0;
			seg_addr_reg <= 8'h00;
			seg_at_reg <= 2'h0;
		end
		else if (is_pcw)
		begin
			first_reg <= control_word_type[0]; // RL1
			seg_addr_reg <= word_reg[`SWF_ADF_HI:`SWF_ADF_LO]; // RL6
			seg_at_reg <= fabric_side_mode_in ? es : 2'h0; // RL5
		end
		else if (!ctl_reg && (phase_reg == swf_pkg::SWF_PH_PAYLOAD))
		begin
			first_reg <= 1'b0;
		end
	end

	// the last data word is held back until the next word tells if it ends a packet
	always_comb
	begin
		push_word = pend_reg;
		push_valid = 1'b0;
		if (pend_valid_reg)
		begin
			if (ctl_reg)
			begin
				push_valid = 1'b1;
				if (es_valid && (es != `SWF_ES_NONE))
				begin
					push_word.packet_last_marker = 1'b1; // RL4 RL3
					push_word.abort = (es == `SWF_ES_ABORT); // RL4
					push_word.last_one_byte = (es == `SWF_ES_ONE); // RL4
				end
			end
			else if (phase_reg == swf_pkg::SWF_PH_PAYLOAD)
			begin
				push_valid = 1'b1; // RL16
			end
		end
	end

	// pending data word; address and training data never enter the payload path
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend_valid_reg <= 1'b0;
			pend_reg <= '0;
		end
		else if (ctl_reg)
		begin
			pend_valid_reg <= 1'b0;
		end
		else if (phase_reg == swf_pkg::SWF_PH_PAYLOAD)
		begin
			pend_valid_reg <= 1'b1; // RL10
			pend_reg.data <= word_reg; // RL10
			pend_reg.packet_first_marker <= first_reg;
			pend_reg.packet_last_marker <= 1'b0;
			pend_reg.abort <= 1'b0;
			pend_reg.last_one_byte <= 1'b0;
			pend_reg.address_field <= seg_addr_reg;
			pend_reg.address_type_code <= seg_at_reg;
		end
	end

	// the link cannot be stalled, so a full buffer drops the word and says so
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			overflow_reg <= 1'b0;
		end
		else
		begin
			overflow_reg <= push_valid && !fifo_ready;
		end
	end

	swf_fifo #(
		.WIDTH(swf_pkg::SWF_PKT_W),
		.DEPTH(`SWF_FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.in_valid_in(push_valid),
		.in_data_in(push_word),
		.in_ready_out(fifo_ready),
		.out_valid_out(pkt_valid_out),
		.out_data_out(pkt_word_out),
		.out_ready_in(pkt_ready_in)
	);

	assign parity_err_out = parity_err_reg;
	assign overflow_out = overflow_reg;
	assign training_out = in_train_reg;
	assign ext_addr_out = ext_addr_reg;

endmodule // swf_sink

// ==== rtl/swf_consts.svh ====
/*
 Constants for the streaming word framer sink: word field positions,
 control word type codes, end status codes and fixed training patterns.
 Assumes it is included by bare name from the package and the design file.
*/
`ifndef SWF_CONSTS_SVH
`define SWF_CONSTS_SVH

// control word type bits sit apart on the word
`define SWF_CWT_HI_BIT 15
`define SWF_CWT_LO_BIT 12
// end status or address type field
`define SWF_ES_HI 14
`define SWF_ES_LO 13
// address field in idle and payload control words
`define SWF_ADF_HI 11
`define SWF_ADF_LO 4
// address field in address control words
`define SWF_ACW_ADF_HI 11
// parity nibble
`define SWF_DIP_HI 3
// control word type codes
`define SWF_CWT_IDLE 2'h0
`define SWF_CWT_ADDR 2'h1
`define SWF_CWT_PAY 2'h2
`define SWF_CWT_PAY_SOP 2'h3
// end status codes
`define SWF_ES_NONE 2'h0
`define SWF_ES_ABORT 2'h1
`define SWF_ES_TWO 2'h2
`define SWF_ES_ONE 2'h3
// training words
`define SWF_TRAIN_CTL 16'h0fff
`define SWF_TRAIN_DATA 16'hf000
// parity slot filler and accumulator reset value
`define SWF_DIP_FILL 4'hf
`define SWF_ACC_RESET 16'h0000
// delivery buffer depth
`define SWF_FIFO_DEPTH 16

`endif

// ==== rtl/swf_pkg.sv ====
/*
 Types shared by the streaming word framer sink.
 Assumes swf_consts.svh is on the include path.
*/
`include "swf_consts.svh"

package swf_pkg;

	// receiver view of where the stream stands
	typedef enum logic [1:0] {
		SWF_PH_IDLE,
		SWF_PH_ADDR,
		SWF_PH_PAYLOAD,
		SWF_PH_TRAIN
	} swf_phase_t;

	// one delivered payload word with its framing marks
	typedef struct packed {
		logic [15:0] data;
		logic packet_first_marker;
		logic packet_last_marker;
		logic abort;
		logic last_one_byte;
		logic [7:0] address_field;
		logic [1:0] address_type_code;
	} swf_pkt_t;

	localparam int SWF_PKT_W = $bits(swf_pkt_t);

endpackage

// ==== tb/swf_sink_sva.sv ====
/*
 Checker for the framer sink: parity flag, status outputs and delivery hold.
 Assumes it is bound onto swf_sink and sees only its ports, one clock.
*/
module swf_sink_chk (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// link pins
	input wire logic [15:0] link_word_in,
	input wire logic link_ctl_in,
	input wire logic fabric_side_mode_in,
	// delivery
	input wire logic pkt_valid_out,
	input wire swf_pkg::swf_pkt_t pkt_word_out,
	input wire logic pkt_ready_in,
	// status
	input wire logic parity_err_out,
	input wire logic overflow_out,
	input wire logic training_out,
	input wire logic [11:0] ext_addr_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] acc_reg;
	logic [15:0] sum;
	logic [7:0] fold;
	logic pbear;
	logic mis;
	// own diagonal sum of the pins; address control words carry no parity
	assign pbear = link_ctl_in && !(!link_word_in[15] && link_word_in[12]);
	assign sum = {acc_reg[14:0], acc_reg[15]} ^ (pbear ? {link_word_in[15:4], 4'hf} : link_word_in);
	assign fold = sum[15:8] ^ sum[7:0];
	assign mis = pbear && ((fold[7:4] ^ fold[3:0]) != link_word_in[3:0]);
	// restart after each parity word so coverage matches the sink
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			acc_reg <= 16'h0000;
		else
			acc_reg <= pbear ? 16'h0000 : sum;
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);
	parity_flag_a: assert property (parity_err_out == $past(mis, 3))
		else $error("parity flag disagrees with pin parity");
	ext_addr_a: assert property (link_ctl_in && !link_word_in[15] && link_word_in[12]
		|-> ##3 ext_addr_out == $past(link_word_in[11:0], 3)) else $error("address word lost");
	train_set_a: assert property (link_ctl_in && link_word_in == 16'h0fff |-> ##3 training_out)
		else $error("training flag not set");
	train_clear_a: assert property (link_ctl_in && link_word_in != 16'h0fff |-> ##3 !training_out)
		else $error("training flag not cleared");
	valid_hold_a: assert property (pkt_valid_out && !pkt_ready_in
		|=> pkt_valid_out && $stable(pkt_word_out)) else $error("delivered word not held");
	ovf_full_a: assert property (overflow_out |-> pkt_valid_out)
		else $error("drop while buffer not full");
	end_mark_a: assert property (pkt_valid_out && (pkt_word_out.abort || pkt_word_out.last_one_byte)
		|-> pkt_word_out.packet_last_marker) else $error("end status without last mark");
	code_excl_a: assert property (pkt_valid_out && pkt_word_out.abort |-> !pkt_word_out.last_one_byte)
		else $error("abort and one byte together");
endmodule // swf_sink_chk

bind swf_sink swf_sink_chk u_swf_sink_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
	.link_word_in(link_word_in), .link_ctl_in(link_ctl_in),
	.fabric_side_mode_in(fabric_side_mode_in), .pkt_valid_out(pkt_valid_out),
	.pkt_word_out(pkt_word_out), .pkt_ready_in(pkt_ready_in), .parity_err_out(parity_err_out),
	.overflow_out(overflow_out), .training_out(training_out), .ext_addr_out(ext_addr_out));

// ==== tb/swf_src_model.sv ====
/*
 Source device model: sends queued words one per cycle, fills parity slots.
 Assumes the bench queues whole control sequences through push.
*/
module swf_src_model (
	// clock and start
	input wire logic clk_in,
	input wire logic run_in,
	// link pins toward the sink
	output logic [15:0] link_word_out,
	output logic link_ctl_out,
	// words still queued
	output int pend_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [17:0] q[$];
	logic [17:0] e;
	logic [15:0] w;
	logic [15:0] acc = 16'h0000;
	logic [7:0] f;
	// queue depth kept as a plain variable; a queue method in a continuous assign is not portable
	initial link_word_out = 16'h000f;
	initial link_ctl_out = 1'b1;
	// bad flips the parity, only when a test asks for it
	task automatic push(input logic bad, input logic ctl, input logic [15:0] word);
		q.push_back({bad, ctl, word});
		pend_out = q.size();
	endtask
	// one word per cycle, idle words when nothing is queued
	always @(negedge clk_in)
	begin
		if (!run_in || q.size() == 0)
			e = 18'h10000;
		else
			e = q.pop_front();
		pend_out = q.size();
		w = e[15:0];
		if (e[16] && !(!w[15] && w[12]))
		begin
			// slot as ones, fold bytes then nibbles; flag never summed
			acc = {acc[14:0], acc[15]} ^ {w[15:4], 4'hf};
			f = acc[15:8] ^ acc[7:0];
			w[3:0] = f[7:4] ^ f[3:0] ^ {4{e[17]}};
			acc = 16'h0000;
		end
		else
			acc = {acc[14:0], acc[15]} ^ w;
		link_word_out <= w;
		link_ctl_out <= e[16];
	end
endmodule // swf_src_model

// ==== tb/tb_top.sv ====
/*
 Self-checking bench for the framer sink with a source model and a
 randomly stalling drain. Assumes the package, sink and model compile first.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
	$display("unexpected at %0t got %h expected %h", $time, got, exp); end end
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic run = 1'b0;
	logic fab = 1'b0;
	logic rdy = 1'b0;
	logic hold = 1'b0;
	logic [15:0] lw;
	logic lc;
	logic pv, pe, ov, tr;
	logic [11:0] xo;
	logic [11:0] xa;
	int pend;
	swf_pkg::swf_pkt_t pw;
	swf_pkg::swf_pkt_t e;
	swf_pkg::swf_pkt_t exp_q[$];
	int bad_count = 0, num_checks = 0, errs = 0, ovfs = 0;
	always #20 clk_in = ~clk_in;
	swf_sink u_swf_sink (.clk_in(clk_in), .arst_n_in(arst_n_in), .link_word_in(lw),
		.link_ctl_in(lc), .fabric_side_mode_in(fab), .pkt_valid_out(pv), .pkt_word_out(pw),
		.pkt_ready_in(rdy), .parity_err_out(pe), .overflow_out(ov), .training_out(tr),
		.ext_addr_out(xo));
	swf_src_model u_swf_src_model (.clk_in(clk_in), .run_in(run), .link_word_out(lw),
		.link_ctl_out(lc), .pend_out(pend));
	// drain stalls at random unless a test holds it off
	always @(negedge clk_in)
		rdy <= !hold && ($urandom_range(3) != 0);
	// score taken words in order; address type must read zero outside fabric mode
	always @(posedge clk_in)
	begin
		errs += pe;
		ovfs += ov;
		if (pv && rdy)
		begin
			e = exp_q.size() ? exp_q.pop_front() : 30'h0;
			`CHK(pw, e)
		end
	end
	// expected delivered word; end status applies to the last data word only
	function automatic swf_pkg::swf_pkt_t exp_word(input logic [15:0] d, input logic first,
		input logic last, input logic [1:0] es, input logic [7:0] a, input logic [1:0] at);
		exp_word = '{d, first, last && es != 2'h0, last && es == 2'h1, last && es == 2'h3, a,
			fab ? at : 2'h0};
	endfunction
	// queue a burst: optional address words, payload word, data, closing idle
	task automatic burst(input bit ext, input int nadw, input int n, input logic [1:0] es,
		input logic sop);
		logic [7:0] a;
		logic [1:0] at;
		logic [15:0] d;
		a = 8'($urandom);
		at = 2'($urandom);
		if (ext)
		begin
			xa = 12'($urandom);
			u_swf_src_model.push(1'b0, 1'b1, {4'h1, xa});
			repeat (nadw)
				u_swf_src_model.push(1'b0, 1'b0, 16'($urandom));
		end
		// status bits here never follow payload data, so they must be ignored
		u_swf_src_model.push(1'b0, 1'b1, {1'b1, at, sop, a, 4'h0});
		for (int i = 0; i < n; i++)
		begin
			d = 16'($urandom);
			u_swf_src_model.push(1'b0, 1'b0, d);
			exp_q.push_back(exp_word(d, sop && i == 0, i == n - 1, es, a, at));
		end
		u_swf_src_model.push(1'b0, 1'b1, {1'b0, es, 13'h0000});
	endtask
	// bounded wait for source queue, sink and drain to empty
	task automatic settle();
		int k;
		k = 0;
		while ((pend != 0 || exp_q.size() != 0 || pv) && k < 400)
		begin
			@(negedge clk_in);
			k++;
		end
		repeat (6)
			@(negedge clk_in);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		void'($urandom(83));
		repeat (10)
			@(negedge clk_in);
		arst_n_in = 1'b1;
		repeat (3)
			@(negedge clk_in);
		run = 1'b1;
		// every end status, single-word and longer bursts
		for (int s = 0; s < 8; s++)
			burst(1'b0, 0, s < 4 ? 1 : $urandom_range(2, 6), 2'(s), 1'($urandom));
		settle();
		`CHK(exp_q.size(), 0)
		// extended bursts with zero to eight address data words
		fab = 1'b1;
		for (int s = 0; s < 9; s++)
		begin
			burst(1'b1, s, $urandom_range(1, 4), 2'($urandom), 1'($urandom));
			settle();
			`CHK(xo, xa)
		end
		fab = 1'b0;
		// one idle word with a wrong parity nibble
		u_swf_src_model.push(1'b1, 1'b1, 16'h0000);
		settle();
		`CHK(errs, 1)
		// training pattern, then the idles that follow clear the flag
		repeat (10)
			u_swf_src_model.push(1'b0, 1'b1, 16'h0fff);
		repeat (10)
			u_swf_src_model.push(1'b0, 1'b0, 16'hf000);
		while (pend != 0)
			@(negedge clk_in);
		`CHK(tr, 1'b1)
		settle();
		`CHK(tr, 1'b0)
		// long burst into a stalled drain until words are dropped
		hold = 1'b1;
		burst(1'b0, 0, 24, 2'h2, 1'b1);
		while (pend != 0)
			@(negedge clk_in);
		repeat (8)
			@(negedge clk_in);
		hold = 1'b0;
		settle();
		`CHK(ovfs, exp_q.size())
		`CHK(ovfs > 0, 1'b1)
		`CHK(errs, 1)
		close_out();
	end
	// cut a hang well beyond the expected run length
	initial
	begin
		#2000000;
		bad_count++;
		close_out();
	end
endmodule // tb_top
